// File: core/fcnsl_pkg.sv
// Constants and types for the flash command next-state logic.
// Assumes one 200 MHz clock and command writes already decoded to bytes.
// Operation
// (R1) From an idle completion state each command code selects its mode.
// (R2) Status read, both suspended: 0xd0 resumes, 0xb0 stays, else array.
// (R3) Array read, both suspended: 0xd0 resumes, 0xb0 status, else stays.
// (R4) Query read, both suspended: 0xd0 resumes, 0xb0 status, else array.
// (R5) After factory confirm, wait over 5 us with ready low and busy high.
// (R6) Load counts 31 down per word, programs at 0, exits on a block change.
package fcnsl_pkg;
  // ==========================================================
  // Command codes
  localparam logic [7:0] FCNSL_CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] FCNSL_CMD_PROG_A     = 8'h10;
  localparam logic [7:0] FCNSL_CMD_PROG_B     = 8'h40;
  localparam logic [7:0] FCNSL_CMD_WBUF       = 8'he8;
  localparam logic [7:0] FCNSL_CMD_FACTORY    = 8'h30;
  localparam logic [7:0] FCNSL_CMD_ERASE      = 8'h20;
  localparam logic [7:0] FCNSL_CMD_CONFIRM    = 8'hd0;
  localparam logic [7:0] FCNSL_CMD_SUSPEND    = 8'hb0;
  // ==========================================================
  // Timing, load count and widths
  localparam int CLK_MHZ          = 200;
  localparam int SETUP_US         = 5;
  localparam int SETUP_CYC        = SETUP_US * CLK_MHZ;
  localparam int PROG_CYC         = 16;
  localparam int EXIT_CYC         = 16;
  localparam logic [4:0] LOAD_INIT = 5'h1f;
  localparam int BLK_W            = 8;
  localparam int DATA_W           = 16;
  // ==========================================================
  // States
  typedef enum logic [3:0] {
    ST_PROG_DONE, ST_READ_ARRAY, ST_READ_STATUS, ST_PROG_SETUP,
    ST_WBUF_SETUP, ST_FACT_SETUP, ST_ERASE_SETUP, ST_PROG_BUSY_ES,
    ST_RS_BOTH, ST_RA_BOTH, ST_RC_BOTH, ST_RQ_BOTH,
    ST_FACT_DELAY, ST_FACT_LOAD, ST_FACT_BUSY, ST_FACT_EXIT_BUSY
  } fcnsl_state_t;
  // Read data source
  typedef enum logic [1:0] {
    SRC_STATUS, SRC_ARRAY, SRC_CONFIG, SRC_QUERY
  } fcnsl_src_t;
endpackage

// File: core/fcnsl_buf2.sv
// Two-entry skid buffer for factory-program data words.
// Assumes both sides on mclk_in.
`timescale 1ns/10ps
module fcnsl_buf2
  import fcnsl_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk_in,
  input  wire logic              sys_rst_in,
  // Fill side
  input  wire logic              in_valid_in,
  output logic                   in_ready_out,
  input  wire logic [DATA_W-1:0] in_data_in,
  // Drain side
  output logic                   out_valid_out,
  input  wire logic              out_ready_in,
  output logic [DATA_W-1:0]      out_data_out
);
  logic [DATA_W-1:0] mem [2];
  logic [DATA_W-1:0] next_mem [2];
  logic              wp, rp, next_wp, next_rp;
  logic [1:0]        cnt, next_cnt;
  logic              push, pop;

  // =========================================================
  // Pointer and storage update
  always_comb
  begin
    push = in_valid_in && (cnt != 2'h2);
    pop  = (cnt != 2'h0) && out_ready_in;
    next_mem = mem;
    next_wp = wp;
    next_rp = rp;
    next_cnt = cnt;
    if (push)
    begin
      next_mem[wp] = in_data_in;
      next_wp = ~wp;
    end
    if (pop)
      next_rp = ~rp;
    next_cnt = 2'(cnt + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      wp  <= 1'b0;
      rp  <= 1'b0;
      cnt <= 2'h0;
    end
    else
    begin
      wp  <= next_wp;
      rp  <= next_rp;
      cnt <= next_cnt;
    end
    mem <= next_mem;
  end

  // Honest full and empty
  assign in_ready_out  = (cnt != 2'h2);
  assign out_valid_out = (cnt != 2'h0);
  assign out_data_out  = mem[rp];
endmodule

// File: core/fcnsl_top.sv
// Command interface next-state logic of a NOR flash.
// Assumes commands arrive as one-cycle strobes on mclk_in.
`timescale 1ns/10ps
module fcnsl_top
  import fcnsl_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk_in,
  input  wire logic              sys_rst_in,
  // Command writes
  input  wire logic              cmd_valid_in,
  input  wire logic [7:0]        cmd_code_in,
  input  wire logic [BLK_W-1:0]  cmd_block_in,
  // Factory-program data writes
  input  wire logic              data_valid_in,
  output logic                   data_ready_out,
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic [BLK_W-1:0]  data_block_in,
  // Array programming side
  output logic                   prog_valid_out,
  input  wire logic              prog_ready_in,
  output logic [DATA_W-1:0]      prog_data_out,
  // Status
  output logic                   ready_status_bit_out,
  output logic                   factory_buffer_busy_bit_out,
  output fcnsl_src_t             read_src_out,
  output fcnsl_state_t           state_out
);
  localparam logic [10:0] SETUP_LIM = 11'(SETUP_CYC);
  localparam logic [10:0] PROG_LIM  = 11'(PROG_CYC);
  localparam logic [10:0] EXIT_LIM  = 11'(EXIT_CYC);

  fcnsl_state_t     state, next_state;
  logic [10:0]      timer, next_timer;
  logic [4:0]       load_cnt, next_load_cnt;
  logic [BLK_W-1:0] blk, next_blk;
  logic             buf_valid, buf_ready;
  logic [DATA_W-1:0] buf_data;
  logic             load_take, blk_change;

  // =========================================================
  // Data buffer; draining stalls when the array side is busy
  fcnsl_buf2 u_buf (
    .mclk_in       (mclk_in),
    .sys_rst_in    (sys_rst_in),
    .in_valid_in   (data_valid_in),
    .in_ready_out  (data_ready_out),
    .in_data_in    (data_in),
    .out_valid_out (buf_valid),
    .out_ready_in  (buf_ready),
    .out_data_out  (buf_data)
  );

  assign blk_change = data_block_in != blk;
  // Words only leave the buffer while loading and the array accepts
  assign buf_ready = (state == ST_FACT_LOAD) && prog_ready_in && !blk_change;
  assign load_take = buf_valid && buf_ready;
  assign prog_valid_out = (state == ST_FACT_LOAD) && buf_valid && !blk_change;
  // Head word rides with valid; a registered copy would lag one word
  assign prog_data_out = buf_data;

  // =========================================================
  // Next-state decode
  always_comb
  begin
    next_state = state;
    next_timer = timer;
    next_load_cnt = load_cnt;
    next_blk = blk;
    case (state)
      ST_PROG_DONE, ST_READ_ARRAY, ST_READ_STATUS:
        if (cmd_valid_in)
          case (cmd_code_in)
            FCNSL_CMD_READ_ARRAY: next_state = ST_READ_ARRAY; // R1
            FCNSL_CMD_PROG_A,
            FCNSL_CMD_PROG_B:     next_state = ST_PROG_SETUP; // R1
            FCNSL_CMD_WBUF:       next_state = ST_WBUF_SETUP; // R1
            FCNSL_CMD_FACTORY:    next_state = ST_FACT_SETUP; // R1
            FCNSL_CMD_ERASE:      next_state = ST_ERASE_SETUP; // R1
            FCNSL_CMD_CONFIRM:    next_state = ST_READ_ARRAY; // R1
            FCNSL_CMD_SUSPEND:    next_state = ST_READ_STATUS; // R1
            default:              next_state = state;
          endcase
      ST_FACT_SETUP:
        if (cmd_valid_in)
        begin
          // Anything but confirm abandons the setup
          if (cmd_code_in == FCNSL_CMD_CONFIRM)
          begin
            next_state = ST_FACT_DELAY;
            next_timer = 11'h000;
            next_blk = cmd_block_in;
          end
          else
            next_state = ST_READ_STATUS;
        end
      ST_FACT_DELAY:
      begin
        next_timer = 11'(timer + 11'h001);
        if (timer >= SETUP_LIM) // R5
        begin
          next_state = ST_FACT_LOAD;
          next_load_cnt = LOAD_INIT; // R6
        end
      end
      ST_FACT_LOAD:
        if (buf_valid && blk_change)
        begin
          next_state = ST_FACT_EXIT_BUSY; // R6
          next_timer = 11'h000;
        end
        else if (load_take)
        begin
          if (load_cnt == 5'h00)
          begin
            next_state = ST_FACT_BUSY; // R6
            next_timer = 11'h000;
          end
          else
            next_load_cnt = 5'(load_cnt - 5'h01); // R6
        end
      ST_FACT_BUSY:
      begin
        next_timer = 11'(timer + 11'h001);
        if (timer >= PROG_LIM)
        begin
          next_state = ST_FACT_LOAD;
          next_load_cnt = LOAD_INIT;
        end
      end
      ST_FACT_EXIT_BUSY:
      begin
        // Internally timed exit ends ready
        next_timer = 11'(timer + 11'h001);
        if (timer >= EXIT_LIM)
          next_state = ST_PROG_DONE; // R6
      end
      ST_RS_BOTH:
        if (cmd_valid_in)
        begin
          if (cmd_code_in == FCNSL_CMD_CONFIRM)
            next_state = ST_PROG_BUSY_ES; // R2
          else if (cmd_code_in == FCNSL_CMD_SUSPEND)
            next_state = ST_RS_BOTH; // R2
          else
            next_state = ST_RA_BOTH; // R2
        end
      ST_RA_BOTH:
        if (cmd_valid_in)
        begin
          if (cmd_code_in == FCNSL_CMD_CONFIRM)
            next_state = ST_PROG_BUSY_ES; // R3
          else if (cmd_code_in == FCNSL_CMD_SUSPEND)
            next_state = ST_RS_BOTH; // R3
        end
      ST_RC_BOTH, ST_RQ_BOTH:
        if (cmd_valid_in)
        begin
          if (cmd_code_in == FCNSL_CMD_CONFIRM)
            next_state = ST_PROG_BUSY_ES; // R4
          else if (cmd_code_in == FCNSL_CMD_SUSPEND)
            next_state = ST_RS_BOTH; // R4
          else
            next_state = ST_RA_BOTH; // R4
        end
      ST_ERASE_SETUP:
        // Erase busy, suspend and program setup rows sit outside this
        // block; a confirmed erase setup stands in for that whole path
        if (cmd_valid_in)
        begin
          if (cmd_code_in == FCNSL_CMD_CONFIRM)
            next_state = ST_PROG_BUSY_ES;
          else
            next_state = ST_READ_STATUS;
        end
      ST_PROG_BUSY_ES:
        // Suspending again returns to both suspended
        if (cmd_valid_in && cmd_code_in == FCNSL_CMD_SUSPEND)
          next_state = ST_RS_BOTH;
      default:
        // Rows handled elsewhere park here until any command, which goes to status read
        if (cmd_valid_in)
          next_state = ST_READ_STATUS;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      state    <= ST_READ_ARRAY;
      timer    <= 11'h000;
      load_cnt <= LOAD_INIT;
      blk      <= '0;
    end
    else
    begin
      state    <= next_state;
      timer    <= next_timer;
      load_cnt <= next_load_cnt;
      blk      <= next_blk;
    end
  end

  // =========================================================
  // Status bits and read source by state
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      ready_status_bit_out        <= 1'b1;
      factory_buffer_busy_bit_out <= 1'b0;
      read_src_out                <= SRC_ARRAY;
      state_out                   <= ST_READ_ARRAY;
    end
    else
    begin
      ready_status_bit_out <= !(next_state inside {ST_FACT_DELAY,
        ST_FACT_LOAD, ST_FACT_BUSY, ST_FACT_EXIT_BUSY, ST_PROG_BUSY_ES});
      factory_buffer_busy_bit_out <= next_state inside {ST_FACT_DELAY,
        ST_FACT_BUSY, ST_FACT_EXIT_BUSY}; // R5
      case (next_state)
        ST_READ_ARRAY, ST_RA_BOTH: read_src_out <= SRC_ARRAY; // R3
        ST_RC_BOTH:                read_src_out <= SRC_CONFIG;
        ST_RQ_BOTH:                read_src_out <= SRC_QUERY; // R4
        default:                   read_src_out <= SRC_STATUS; // R2
      endcase
      state_out <= next_state;
    end
  end
endmodule

// File: verification/fcnsl_array_model.sv
// Array-side model: takes programming words, stalls on request.
// Assumes the bench moves stall_in just after a clock edge.
`timescale 1ns/10ps
module fcnsl_array_model
(
  // Clock
  input  wire logic        mclk_in,
  // Bench control
  input  wire logic        stall_in,
  // Programming handshake
  input  wire logic        prog_valid_in,
  input  wire logic [15:0] prog_data_in,
  output logic             prog_ready_out,
  output int               word_cnt_out = 0,
  output logic [15:0]      word_sum_out = 16'h0000
);
  // Ready follows the stall; each word taken is counted and summed
  assign prog_ready_out = !stall_in;
  always @(posedge mclk_in)
    if (prog_valid_in && prog_ready_out)
    begin
      word_cnt_out <= word_cnt_out + 1;
      word_sum_out <= word_sum_out ^ prog_data_in;
    end
endmodule

// File: verification/fcnsl_props.sv
// Checker for fcnsl_top command and status ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module fcnsl_props
  import fcnsl_pkg::*;
(
  // Clock and reset
  input wire logic         mclk_in,
  input wire logic         sys_rst_in,
  // Commands
  input wire logic         cmd_valid_in,
  input wire logic [7:0]   cmd_code_in,
  // Status
  input wire logic         ready_status_bit_out,
  input wire logic         factory_buffer_busy_bit_out,
  input wire fcnsl_state_t state_out
);
  // ==========
  // Helpers
  fcnsl_state_t idle_next;
  logic [10:0]  dcnt;
  logic [10:0]  next_dcnt;
  logic         dly;
  assign dly = state_out == ST_FACT_DELAY;
  // Idle decode; unknown codes leave the state alone
  always_comb
  begin
    case (cmd_code_in)
      8'hff, 8'hd0: idle_next = ST_READ_ARRAY;
      8'h10, 8'h40: idle_next = ST_PROG_SETUP;
      8'he8: idle_next = ST_WBUF_SETUP;
      8'h30: idle_next = ST_FACT_SETUP;
      8'h20: idle_next = ST_ERASE_SETUP;
      8'hb0: idle_next = ST_READ_STATUS;
      default: idle_next = ST_PROG_DONE;
    endcase
  end
  // Delay length; wide enough, so no wrap inside one delay
  always_comb next_dcnt = dly ? dcnt + 11'h001 : 11'h000;
  always_ff @(posedge mclk_in) dcnt <= sys_rst_in ? 11'h000 : next_dcnt;
  // ==========
  // Properties
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_cmd(logic [7:0] c);
    cmd_valid_in && cmd_code_in == c;
  endsequence
  sequence s_exit_done;
    state_out == ST_FACT_EXIT_BUSY ##1 state_out == ST_PROG_DONE;
  endsequence
  a_idle_dispatch: assert property (
    state_out == ST_PROG_DONE && cmd_valid_in
    |=> state_out == $past(idle_next)) else $error("idle dispatch");
  a_rs_other_array: assert property (
    state_out == ST_RS_BOTH && cmd_valid_in && cmd_code_in != 8'hd0
    && cmd_code_in != 8'hb0 |=> state_out == ST_RA_BOTH)
    else $error("status read exit");
  a_rs_resume: assert property (
    state_out == ST_RS_BOTH ##0 s_cmd(8'hd0)
    |=> state_out == ST_PROG_BUSY_ES) else $error("status resume");
  a_ra_hold: assert property (
    state_out == ST_RA_BOTH && cmd_valid_in && cmd_code_in != 8'hd0
    && cmd_code_in != 8'hb0 |=> state_out == ST_RA_BOTH)
    else $error("array read hold");
  a_ra_to_status: assert property (
    state_out == ST_RA_BOTH ##0 s_cmd(8'hb0) |=> state_out == ST_RS_BOTH)
    else $error("array read exit");
  a_rq_resume: assert property (
    state_out == ST_RQ_BOTH ##0 s_cmd(8'hd0)
    |=> state_out == ST_PROG_BUSY_ES) else $error("query resume");
  a_delay_flags: assert property (
    dly |-> !ready_status_bit_out && factory_buffer_busy_bit_out)
    else $error("delay flags");
  a_delay_length: assert property (
    $fell(dly) |-> state_out == ST_FACT_LOAD && dcnt > 11'h3e8
    && dcnt < 11'h3ec) else $error("delay length");
  a_exit_ready: assert property (
    s_exit_done |-> ready_status_bit_out && !factory_buffer_busy_bit_out)
    else $error("exit flags");
endmodule
bind fcnsl_top fcnsl_props u_props (.mclk_in, .sys_rst_in, .cmd_valid_in,
  .cmd_code_in, .ready_status_bit_out, .factory_buffer_busy_bit_out,
  .state_out);

// File: verification/tb_fcnsl_top.sv
// Bench: factory sessions, then one idle command each.
// Assumes fcnsl_props is bound in by its own file.
`timescale 1ns/10ps
module tb_fcnsl_top;
  import fcnsl_pkg::*;
  // ==========
  // Signals
  logic         mclk_in = 1'b0;
  logic         sys_rst_in = 1'b1;
  logic         cmd_valid_in = 1'b0;
  logic [7:0]   cmd_code_in = 8'h00;
  logic [7:0]   cmd_block_in = 8'h00;
  logic         data_valid_in = 1'b0;
  logic [15:0]  data_in = 16'h0000;
  logic [7:0]   data_block_in = 8'h00;
  logic         stall = 1'b0;
  logic         data_ready_out, prog_valid_out, prog_ready_in;
  logic         ready_status_bit_out, factory_buffer_busy_bit_out;
  fcnsl_src_t   read_src_out;
  fcnsl_state_t state_out;
  logic [31:0]  seed = 32'h0000_0616;
  logic [7:0]   blk = 8'h00;
  logic [15:0]  prog_data, word_sum, exp_sum = 16'h0000;
  int           word_cnt, mismatches = 0, n_tests = 0;
  fcnsl_top DUT (.mclk_in, .sys_rst_in, .cmd_valid_in, .cmd_code_in,
    .cmd_block_in, .data_valid_in, .data_ready_out, .data_in,
    .data_block_in, .prog_valid_out, .prog_ready_in,
    .prog_data_out(prog_data),
    .ready_status_bit_out, .factory_buffer_busy_bit_out, .read_src_out,
    .state_out);
  fcnsl_array_model u_array (.mclk_in, .stall_in(stall),
    .prog_valid_in(prog_valid_out), .prog_data_in(prog_data),
    .prog_ready_out(prog_ready_in), .word_cnt_out(word_cnt),
    .word_sum_out(word_sum));
  always #2.5 mclk_in = ~mclk_in;
  // ==========
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic fcnsl_state_t idle_exp(input logic [7:0] c);
    case (c)
      8'hff, 8'hd0: return ST_READ_ARRAY;
      8'h10, 8'h40: return ST_PROG_SETUP;
      8'he8: return ST_WBUF_SETUP;
      8'h30: return ST_FACT_SETUP;
      8'h20: return ST_ERASE_SETUP;
      8'hb0: return ST_READ_STATUS;
      default: return ST_PROG_DONE;
    endcase
  endfunction
  // Both suspended: 0xd0 resumes, 0xb0 reads status, others read array
  function automatic fcnsl_state_t both_exp(input fcnsl_state_t s,
    input logic [7:0] c);
    if (s == ST_PROG_BUSY_ES)
      return (c == 8'hb0) ? ST_RS_BOTH : ST_PROG_BUSY_ES;
    if (c == 8'hd0)
      return ST_PROG_BUSY_ES;
    if (c == 8'hb0)
      return ST_RS_BOTH;
    return ST_RA_BOTH;
  endfunction
  task automatic check(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask
  task automatic flags(input logic r, b);
    check("ready", 16'(r), 16'(ready_status_bit_out));
    check("busy", 16'(b), 16'(factory_buffer_busy_bit_out));
  endtask
  // Inputs always move 1 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  // One-cycle strobe, then a quiet cycle so strobes never abut
  task automatic cmd(input logic [7:0] c);
    cmd_valid_in = 1'b1;
    cmd_code_in = c;
    cmd_block_in = blk;
    cyc(1);
    cmd_valid_in = 1'b0;
    cyc(1);
  endtask
  task automatic wait_st(input fcnsl_state_t s, input int lim);
    for (int i = 0; i < lim && state_out !== s; i++)
      cyc(1);
    check("state", 16'(s), 16'(state_out));
  endtask
  // Word, valid and block hold until an edge with ready settled high
  task automatic word(input logic [7:0] b);
    logic [31:0] r;
    logic        ok;
    r = rnd();
    data_in = r[15:0];
    data_valid_in = 1'b1;
    data_block_in = b;
    ok = 1'b0;
    while (!ok)
    begin
      ok = (data_ready_out === 1'b1);
      cyc(1);
    end
    if (b == blk)
      exp_sum = exp_sum ^ r[15:0];
  endtask
  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========
  // Main sequence
  initial
  begin
    logic [7:0]  codes [9];
    logic [31:0] r;
    int          n;
    logic [7:0]  c;
    fcnsl_state_t s, e;
    r = rnd();
    codes = '{8'hff, 8'h10, 8'h40, 8'he8, 8'h30, 8'h20, 8'hd0, 8'hb0,
      {4'h0, r[3:1], 1'b1}};
    for (int k = 0; k < 9; k++)
    begin
      sys_rst_in = 1'b1;
      cyc(k == 0 ? 6 : 2);
      sys_rst_in = 1'b0;
      wait_st(ST_READ_ARRAY, 0);
      flags(1'b1, 1'b0);
      check("src", 16'(SRC_ARRAY), 16'(read_src_out));
      r = rnd();
      blk = r[15:8];
      cmd(8'h30);
      cmd(8'hd0);
      check("state", 16'(ST_FACT_DELAY), 16'(state_out));
      flags(1'b0, 1'b1);
      for (n = 1; state_out === ST_FACT_DELAY && n < 1100; n++)
        cyc(1);
      check("delay", 16'h0001, 16'(n > SETUP_CYC));
      wait_st(ST_FACT_LOAD, 0);
      flags(1'b0, 1'b0);
      if (k == 0)
      begin
        // Stalled far side: buffer takes two words, then refuses
        stall = 1'b1;
        word(blk);
        word(blk);
        cyc(8);
        check("dready", 16'h0000, 16'(data_ready_out));
        check("words", 16'h0000, 16'(word_cnt));
        stall = 1'b0;
        repeat (30) word(blk);
        data_valid_in = 1'b0;
        wait_st(ST_FACT_BUSY, 40);
        check("words", 16'h0020, 16'(word_cnt));
        check("wsum", exp_sum, word_sum);
        flags(1'b0, 1'b1);
        wait_st(ST_FACT_LOAD, 40);
      end
      word(blk ^ 8'h01);
      data_valid_in = 1'b0;
      wait_st(ST_FACT_EXIT_BUSY, 8);
      flags(1'b0, 1'b1);
      wait_st(ST_PROG_DONE, 40);
      flags(1'b1, 1'b0);
      cmd(codes[k]);
      check("state", 16'(idle_exp(codes[k])), 16'(state_out));
    end
    // Both-suspended reads, reached through a confirmed erase setup
    sys_rst_in = 1'b1;
    cyc(2);
    sys_rst_in = 1'b0;
    cmd(8'h20);
    cmd(8'hd0);
    check("state", 16'(ST_PROG_BUSY_ES), 16'(state_out));
    flags(1'b0, 1'b0);
    for (int j = 0; j < 24; j++)
    begin
      r = rnd();
      s = state_out;
      case (j == 0 ? 2'h1 : r[1:0])
        2'h0: c = 8'hd0;
        2'h1: c = 8'hb0;
        default: c = r[15:8];
      endcase
      e = both_exp(s, c);
      cmd(c);
      check("state", 16'(e), 16'(state_out));
      check("src", 16'(e == ST_RA_BOTH ? SRC_ARRAY : SRC_STATUS),
        16'(read_src_out));
      flags(e != ST_PROG_BUSY_ES, 1'b0);
    end
    results();
  end
  // Run is about 10k cycles; this leaves ample margin
  initial
  begin
    #120us;
    mismatches++;
    results();
  end
endmodule
